// ### dsa_pkg.sv
// constants and types shared by the dual-slope converter sequencer
package dsa_pkg;
  // clock rate of the system clock
  localparam int CLK_MHZ = 200;
  // cycling generator period, about 10 kHz
  localparam int CYCLE_PERIOD_NS = 100000;
  localparam int TICK_CYCLES = CYCLE_PERIOD_NS * CLK_MHZ / 1000;
  // transfer one-shot width, a least time, rounded up
  localparam int ONE_SHOT_NS = 1000;
  localparam int ONE_SHOT_CYCLES = (ONE_SHOT_NS * CLK_MHZ + 999) / 1000;
  // bcd counter landmarks
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_INTEG_END = 16'h6000;
  localparam logic [15:0] COUNT_REF_LIMIT = 16'h8000;
  localparam logic [15:0] COUNT_LAST = 16'h9999;
  localparam logic [3:0] DIGIT_HIGH_ORDER = 4'h6;
  localparam logic [3:0] DIGIT_OVER_ORDER = 4'h8;
  // register byte offsets
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_POL_BIT = 3;
  localparam int STAT_OVER_BIT = 4;
  localparam int RESULT_SIGN_BIT = 16;
  // reset values
  localparam logic CTRL_RUN_RESET = 1'b1;
  // conversion phases
  typedef enum logic [1:0] {
    DSA_INTEGRATE = 2'b00,
    DSA_REFERENCE = 2'b01,
    DSA_IDLE = 2'b10,
    DSA_OVERLOAD = 2'b11
  } dsa_phase_type;
endpackage : dsa_pkg

// ### dsa_sequencer.sv
// dual-slope converter sequencer with avalon-mm register access
`timescale 1ns/1ps
module dsa_sequencer #(
  parameter int TICK_DIV = dsa_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  // analogue side
  input wire logic i_comparator,
  input wire logic i_polarity,
  output logic o_input_switch,
  output logic o_reference_switch,
  output logic o_aux_reference_switch,
  output logic o_transfer_strobe_n,
  output logic [15:0] o_output_store,
  output logic o_minus_sign,
  output logic o_overload,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // ****************************************
  // helpers
  // ****************************************
  // ripple increment of four bcd decades, 9999 wraps to 0000
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (carry) begin
        if (v[d*4 +: 4] == 4'h9) begin
          r[d*4 +: 4] = 4'h0;
        end else begin
          r[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  // ****************************************
  // state
  // ****************************************
  logic [31:0] tick_cnt; // cycling generator divider
  logic [31:0] next_tick_cnt;
  logic tick; // one cycle per cycling clock period
  logic [15:0] count; // four bcd decades, top decade in [15:12]
  logic [15:0] next_count;
  dsa_pkg::dsa_phase_type phase; // current conversion phase
  dsa_pkg::dsa_phase_type next_phase;
  logic done; // completion output of comparison-done flop
  logic next_done;
  logic done_sync; // completion_sync_flipflop
  logic next_done_sync;
  logic polarity; // polarity_flipflop
  logic next_polarity;
  logic comp_meta; // first synchroniser stage, read only by comp_sync
  logic comp_sync;
  logic comp_prev; // previous synchronised level for edge detect
  logic [15:0] one_shot_cnt; // transfer_one_shot remaining cycles
  logic [15:0] next_one_shot_cnt;
  logic [15:0] store; // output_store_digit x4
  logic [15:0] next_store;
  logic sign; // spare bit of top_digit_store
  logic next_sign;
  logic run; // software run enable
  logic next_run;
  logic high_order; // top decade at 6 or above, count from 6000
  logic over_order; // top decade at 8 or above, count above 8000
  logic comp_fall;

  assign tick = (tick_cnt == 32'(TICK_DIV - 1));
  assign high_order = (count[15:12] >= dsa_pkg::DIGIT_HIGH_ORDER);
  assign over_order = (count[15:12] >= dsa_pkg::DIGIT_OVER_ORDER)
    && (count != dsa_pkg::COUNT_REF_LIMIT);
  assign comp_fall = comp_prev & ~comp_sync;

  // ****************************************
  // comparator synchroniser
  // ****************************************
  // two flops before any use; the edge is taken from stage two only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      comp_meta <= 1'b1;
      comp_sync <= 1'b1;
      comp_prev <= 1'b1;
    end else begin
      comp_meta <= i_comparator;
      comp_sync <= comp_meta;
      comp_prev <= comp_sync;
    end
  end

  // ****************************************
  // sequencer next state
  // ****************************************
  // counter, phase and comparison flops in one group
  always_comb begin
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_count = count;
    next_done = done;
    next_done_sync = done_sync;
    next_polarity = polarity;
    if (!run) begin
      // halted: counter parked at zero, ready to integrate
      next_tick_cnt = 32'h0;
      next_count = dsa_pkg::COUNT_ZERO;
      next_done = 1'b0;
      next_done_sync = 1'b0;
    end else begin
      if (tick) begin
        next_count = bcd_inc(count);
        // last integration pulse clocks the polarity flop from i_polarity
        if (bcd_inc(count) == dsa_pkg::COUNT_INTEG_END) begin
          next_polarity = i_polarity;
        end
        next_done_sync = done;
      end
      if (!high_order) begin
        next_done = 1'b0;
        next_done_sync = 1'b0;
      end else if (comp_fall && !done && count < dsa_pkg::COUNT_REF_LIMIT) begin
        // only a crossing below 8000 counts as a valid reading
        next_done = 1'b1;
      end
    end
    // phase follows the counter and the comparison state
    if (!next_count[15] && next_count[15:12] < dsa_pkg::DIGIT_HIGH_ORDER) begin
      next_phase = dsa_pkg::DSA_INTEGRATE;
    end else if (next_done) begin
      next_phase = dsa_pkg::DSA_IDLE;
    end else if (next_count[15:12] >= dsa_pkg::DIGIT_OVER_ORDER
                 && next_count != dsa_pkg::COUNT_REF_LIMIT) begin
      next_phase = dsa_pkg::DSA_OVERLOAD;
    end else begin
      next_phase = dsa_pkg::DSA_REFERENCE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt <= 32'h0;
      count <= dsa_pkg::COUNT_ZERO;
      phase <= dsa_pkg::DSA_INTEGRATE;
      done <= 1'b0;
      done_sync <= 1'b0;
      polarity <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      count <= next_count;
      phase <= next_phase;
      done <= next_done;
      done_sync <= next_done_sync;
      polarity <= next_polarity;
    end
  end

  // ****************************************
  // switch drive
  // ****************************************
  // decoded from the phase; all off while halted
  always_comb begin
    o_input_switch = 1'b0;
    o_reference_switch = 1'b0;
    o_aux_reference_switch = 1'b0;
    case (phase)
      dsa_pkg::DSA_INTEGRATE: begin
        o_input_switch = run;
      end
      dsa_pkg::DSA_REFERENCE: begin
        o_reference_switch = run;
        o_aux_reference_switch = run;
      end
      dsa_pkg::DSA_IDLE: begin
        o_reference_switch = 1'b0;
      end
      default: begin
        // overload: integrator left alone until the wrap
        o_reference_switch = 1'b0;
      end
    endcase
  end

  // ****************************************
  // transfer one-shot and output store
  // ****************************************
  // fires once on the rise of the synced completion
  always_comb begin
    next_one_shot_cnt = one_shot_cnt;
    next_store = store;
    next_sign = sign;
    if (one_shot_cnt != 16'h0) begin
      next_one_shot_cnt = one_shot_cnt - 16'h1;
    end
    if (next_done_sync && !done_sync) begin
      next_one_shot_cnt = 16'(dsa_pkg::ONE_SHOT_CYCLES);
      next_store = count;
      next_sign = polarity;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      one_shot_cnt <= 16'h0;
      store <= 16'h0;
      sign <= 1'b0;
    end else begin
      one_shot_cnt <= next_one_shot_cnt;
      store <= next_store;
      sign <= next_sign;
    end
  end

  // store keeps the old result outside the strobe
  assign o_transfer_strobe_n = (one_shot_cnt == 16'h0);
  assign o_output_store = store;
  assign o_minus_sign = sign;
  assign o_overload = (phase == dsa_pkg::DSA_OVERLOAD);

  // ****************************************
  // avalon-mm slave
  // ****************************************
  // one wait state: read data loads at the first edge and stands at the second;
  // a write lands only at the edge where waitrequest is sampled low
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;

  always_comb begin
    next_ack = (i_avs_read | i_avs_write) & ~ack;
    next_run = run;
    next_readdata = o_avs_readdata;
    if (ack && i_avs_write && i_avs_address == dsa_pkg::REG_CONTROL) begin
      next_run = i_avs_writedata[dsa_pkg::CTRL_RUN_BIT];
    end
    if (next_ack && i_avs_read) begin
      next_readdata = 32'h0; // unmapped reads as zero
      case (i_avs_address)
        dsa_pkg::REG_CONTROL: next_readdata[dsa_pkg::CTRL_RUN_BIT] = run;
        dsa_pkg::REG_STATUS: begin
          next_readdata[1:0] = phase;
          next_readdata[dsa_pkg::STAT_DONE_BIT] = done;
          next_readdata[dsa_pkg::STAT_POL_BIT] = polarity;
          next_readdata[dsa_pkg::STAT_OVER_BIT] = high_order & over_order & ~done;
        end
        dsa_pkg::REG_COUNT: next_readdata[15:0] = count;
        dsa_pkg::REG_RESULT: begin
          next_readdata[15:0] = store;
          next_readdata[dsa_pkg::RESULT_SIGN_BIT] = sign;
        end
        default: next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
      run <= dsa_pkg::CTRL_RUN_RESET;
      o_avs_readdata <= 32'h0;
    end else begin
      ack <= next_ack;
      run <= next_run;
      o_avs_readdata <= next_readdata;
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_integ_switches: assert property (
    (phase == dsa_pkg::DSA_INTEGRATE && run) |->
      o_input_switch && !o_reference_switch && !o_aux_reference_switch)
    else $error("integration switch pattern wrong");
  a_ref_switches: assert property (
    (phase == dsa_pkg::DSA_REFERENCE && run) |->
      !o_input_switch && o_reference_switch && o_aux_reference_switch)
    else $error("reference switch pattern wrong");
  a_done_held: assert property ((run && !high_order) |=> !done)
    else $error("completion high during integration");
  a_store_quiet: assert property (
    (phase == dsa_pkg::DSA_INTEGRATE && $stable(count)) |-> $stable(store))
    else $error("store changed during integration");
  a_integ_end: assert property ($rose(high_order) |-> count == 16'h6000)
    else $error("integration ended at wrong count");
  a_pol_capture: assert property (
    (run && tick && count == 16'h5999) |=> polarity == $past(i_polarity))
    else $error("polarity not captured at integration end");
  a_ref_cut: assert property ($rose(done) |-> !o_reference_switch)
    else $error("reference still on after comparison");
  a_late_cross: assert property (
    (count >= 16'h8000) && !done |=> !done)
    else $error("crossing accepted at or after 8000");
  a_sync_done: assert property ((run && done && tick) |=> done_sync)
    else $error("completion not synced on tick");
  a_one_shot: assert property (
    $fell(o_transfer_strobe_n) |-> !o_transfer_strobe_n [*8] ##1
      (one_shot_cnt == 16'(dsa_pkg::ONE_SHOT_CYCLES - 8)))
    else $error("one-shot width wrong");
  a_store_load: assert property (
    $fell(o_transfer_strobe_n) |-> store == $past(count) && sign == $past(polarity))
    else $error("store not loaded from counter");
  a_overload: assert property (
    (run && over_order && !done) |-> phase == dsa_pkg::DSA_OVERLOAD)
    else $error("overload phase missing");
  a_wrap: assert property ((run && tick && count == 16'h9999) |=> count == 16'h0)
    else $error("counter did not wrap");

  c_conversion: cover property ($fell(o_transfer_strobe_n));
  c_overload: cover property ($rose(o_overload));
  c_wrap: cover property (tick && count == 16'h9999);
  c_bus_write: cover property (i_avs_write && !o_avs_waitrequest);

endmodule : dsa_sequencer

// ### dsa_analog_model.sv
// behavioural integrator and comparator facing the converter sequencer
`timescale 1ns/1ps
module dsa_analog_model (
  input wire logic i_clk,
  input wire logic i_input_switch,
  input wire logic i_reference_switch,
  input wire logic [31:0] i_ref_cycles,
  input wire logic i_negative,
  output logic o_comparator,
  output logic o_polarity
);
  // ****************************************
  // integrator discharge timing
  // ****************************************
  logic [31:0] ref_time; // discharge cycles so far
  initial begin
    ref_time = 32'h0;
    o_comparator = 1'b0;
  end
  // charging sets the comparator high, discharge drops it after the commanded time
  always @(posedge i_clk) begin
    if (i_input_switch) begin
      ref_time <= 32'h0;
      o_comparator <= 1'b1;
    end else if (i_reference_switch) begin
      ref_time <= ref_time + 32'h1;
      // a late crossing is commanded only to provoke an overload
      if (ref_time + 32'h1 >= i_ref_cycles) o_comparator <= 1'b0;
    end
  end
  // sign of the unknown input, steady for a whole cycle
  assign o_polarity = i_negative;
endmodule : dsa_analog_model

// ### dsa_sequencer_test.sv
// self-checking testbench for the dual-slope converter sequencer
`timescale 1ns/1ps
module dsa_sequencer_test;
  // ****************************************
  // signals and rows
  // ****************************************
  localparam int DIV = 2; // short tick keeps the run brief
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic cmp_line, pol_line, sw_in, sw_ref, sw_aux, strobe_n, minus, over, waitreq;
  logic [15:0] store;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic [31:0] ref_cycles = 32'h0; // discharge time handed to the model
  logic neg = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int bad_strobe = 0; // strobe lows seen while integrating
  // discharge ticks, sign and expected overload for each conversion
  int row_ticks [3] = '{100, 1990, 2500};
  logic row_neg [3] = '{1'b0, 1'b1, 1'b0};
  logic row_over [3] = '{1'b0, 1'b0, 1'b1};
  always #2.5 i_clk = ~i_clk;
  dsa_sequencer #(.TICK_DIV(DIV)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_comparator(cmp_line), .i_polarity(pol_line), .o_input_switch(sw_in),
    .o_reference_switch(sw_ref), .o_aux_reference_switch(sw_aux),
    .o_transfer_strobe_n(strobe_n), .o_output_store(store), .o_minus_sign(minus),
    .o_overload(over), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));
  dsa_analog_model far (.i_clk(i_clk), .i_input_switch(sw_in), .i_reference_switch(sw_ref),
    .i_ref_cycles(ref_cycles), .i_negative(neg), .o_comparator(cmp_line),
    .o_polarity(pol_line));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20) check(1, 0);
  endtask : bus
  function automatic logic sig(input int w);
    case (w)
      0: return sw_in;
      1: return sw_ref;
      2: return ~strobe_n;
      default: return over;
    endcase
  endfunction : sig
  // bounded wait for a level, judged at the falling edge
  task automatic wait_on(input int w, input int lim);
    int k;
    k = 0;
    while (sig(w) !== 1'b1 && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    check(sig(w), 1);
  endtask : wait_on
  function automatic int from_bcd(input logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction : from_bcd
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // transfer strobe must not go low while the input is integrating
  always @(negedge i_clk) if (sw_in === 1'b1 && strobe_n !== 1'b1) bad_strobe++;
  // watchdog, about a third above the planned run
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int k, v;
    logic [15:0] prev;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    check({sw_in, sw_ref, sw_aux, strobe_n, minus, over, waitreq}, 7'b1001000);
    check(store, 16'h0000);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(1'b0, dsa_pkg::REG_CONTROL, 32'h0);
    check(q[0], 1'b1);
    bus(1'b1, dsa_pkg::REG_CONTROL, 32'h0);
    bus(1'b0, dsa_pkg::REG_COUNT, 32'h0);
    check(q[15:0], 16'h0000);
    check(sw_in, 1'b0);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
    bus(1'b0, dsa_pkg::REG_CONTROL, 32'h0);
    check(q[0], 1'b0);
    bus(1'b1, dsa_pkg::REG_CONTROL, 32'h1);
    $display("register test done");
    for (int i = 0; i < 3; i++) begin
      wait_on(0, 30000);
      @(posedge i_clk);
      ref_cycles <= row_ticks[i] * DIV;
      neg <= row_neg[i];
      prev = store;
      @(negedge i_clk);
      check({sw_ref, sw_aux, strobe_n, over}, 4'b0010);
      wait_on(1, 20000);
      check({sw_in, sw_aux}, 2'b01);
      bus(1'b0, dsa_pkg::REG_STATUS, 32'h0);
      check({q[3], q[1:0]}, {row_neg[i], 2'b01});
      if (!row_over[i]) begin
        wait_on(2, 10000);
        check({sw_ref, sw_aux}, 2'b00);
        v = from_bcd(store);
        check(v >= 6000 + row_ticks[i] && v <= 6003 + row_ticks[i], 1);
        check(minus, row_neg[i]);
        k = 0;
        while (strobe_n === 1'b0 && k < 1000) begin
          @(negedge i_clk);
          k++;
        end
        check(k, dsa_pkg::ONE_SHOT_CYCLES);
        bus(1'b0, dsa_pkg::REG_STATUS, 32'h0);
        check(q[2], 1'b1);
        bus(1'b0, dsa_pkg::REG_RESULT, 32'h0);
        check(q[16], row_neg[i]);
      end else begin
        wait_on(3, 10000);
        check({sw_in, sw_ref, sw_aux}, 3'b000);
        bus(1'b0, dsa_pkg::REG_STATUS, 32'h0);
        check(q[4], 1'b1);
        check(store, prev);
      end
      $display("conversion %0d done", i);
    end
    wait_on(0, 30000);
    bus(1'b0, dsa_pkg::REG_COUNT, 32'h0);
    check(q[15:12], 4'h0);
    check(bad_strobe, 0);
    $display("wrap test done");
    wrap_up();
  end
endmodule : dsa_sequencer_test
